// ---- pkg/rst_ctrl_params.svh ----
// Constants for the reset controller: bus map, reset values and timing.
// Assumes inclusion by name from rtl and bench files; definitions only.
`ifndef RST_CTRL_PARAMS_SVH
`define RST_CTRL_PARAMS_SVH

// Register word indices (byte address = 4 * index)
`define ADDR_STATUS 4'h0
`define ADDR_WDT_SETUP 4'h1
`define ADDR_INTERRUPT_CONTROL_0 4'h2
`define ADDR_PC_LOW 4'h3
`define ADDR_PORT_A 4'h4
`define ADDR_PORT_A_DIR 4'h5
`define ADDR_ACC 4'h6
`define ADDR_CAUSE 4'h7
`define ADDR_CONFIG 4'h8
`define ADDR_WDT_COUNT 4'h9
`define ADDR_PTR 4'hA

// Reset values
`define WDT_SETUP_RST 8'h07
`define INTERRUPT_CONTROL_0_RST 8'h00
`define PORT_RST 8'hFF
`define PC_RST 8'h00
`define SP_RST 3'h7
`define CONFIG_RST 8'h01
`define INTERRUPT_CONTROL_0_IMPL 8'h7F

// Flag bit positions in the flags register, and the LV enable bit in config
`define FLAG_TO 5
`define FLAG_PD 4
`define CFG_LVR_EN 0

// Timing: reset delay 1 ms, low-voltage qualify 1 ms, clock 100 ns
`define CLK_PERIOD_NS 100
`define RESET_DELAY_NS 1000000
`define LV_QUALIFY_NS 1000000
`define RESET_DELAY_CYC ((`RESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LV_QUALIFY_CYC ((`LV_QUALIFY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- pkg/rst_ctrl_pkg.sv ----
// Types shared by the reset controller.
// Assumes rst_ctrl_params.svh is on the include path.
package rst_ctrl_pkg;
  typedef enum logic [2:0] {
    CAUSE_POWER_ON,
    CAUSE_PIN,
    CAUSE_LOW_VOLTAGE,
    CAUSE_WDT_RUN,
    CAUSE_WDT_SLEEP
  } cause_t;
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_RUN
  } state_t;
endpackage

// ---- rtl/rst_ctrl.sv ----
// Reset controller: merges power-on, pin, low-voltage and watchdog resets,
// holds execution, applies the start-up delay and loads reset values.
// Assumes a classic Wishbone master on clk_i and asynchronous pin inputs.
`include "rst_ctrl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rst_ctrl
  import rst_ctrl_pkg::*;
#(
  parameter int unsigned RESET_DELAY_CYCLES = `RESET_DELAY_CYC,
  parameter int unsigned LV_QUALIFY_CYCLES = `LV_QUALIFY_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic external_reset_pin_n_i,
  input wire logic low_supply_i,
  input wire logic watchdog_timeout_i,
  input wire logic power_down_i,
  input wire logic halt_req_i,
  input wire logic wdt_clear_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic cpu_run_o,
  output logic [7:0] pc_low_o,
  output logic [2:0] stack_ptr_o,
  output logic timers_on_o,
  output logic irq_enable_o,
  output logic [7:0] port_a_o,
  output logic [7:0] port_a_dir_o
);

  // Pin-side inputs pass two flip-flops before use.
  // The stages carry no reset: rst_i must stay high for at least two edges
  // so that both stages hold a real pin level before the sequencer looks.
  // The cost is two cycles of latency on every source, which is far below
  // the start-up delay and so never visible to software.
  logic [1:0] pin_sync_reg;
  logic [1:0] low_sync_reg;
  logic [1:0] wdt_sync_reg;
  logic [1:0] pd_sync_reg;
  logic pin_low;
  logic low_supply;
  logic wdt_event;
  logic in_power_down;

  always_ff @(posedge clk_i)
  begin
    pin_sync_reg <= {pin_sync_reg[0], external_reset_pin_n_i};
    low_sync_reg <= {low_sync_reg[0], low_supply_i};
    wdt_sync_reg <= {wdt_sync_reg[0], watchdog_timeout_i};
    pd_sync_reg <= {pd_sync_reg[0], power_down_i};
  end

  assign pin_low = ~pin_sync_reg[1];
  assign low_supply = low_sync_reg[1];
  assign wdt_event = wdt_sync_reg[1];
  assign in_power_down = pd_sync_reg[1];

  // Registers
  state_t state_reg;
  state_t state_next;
  cause_t cause_reg;
  logic [31:0] delay_cnt_reg;
  logic [31:0] lv_cnt_reg;
  logic [7:0] config_reg;
  logic [7:0] flags_reg;
  logic [7:0] wdt_setup_reg;
  logic [7:0] interrupt_control_0_reg;
  logic [7:0] acc_reg;
  logic [7:0] ptr_reg;
  logic [15:0] wdt_count_reg;
  logic cold_reg;

  // Low supply is qualified by a persistence counter; short dips are ignored.
  // The counter saturates at the qualify count, so a long brown-out keeps
  // the reset asserted without the count wrapping back into a short dip.
  // Clearing the enable bit drops the count, so a later enable starts afresh.
  logic lv_enabled;
  logic lv_fire;
  assign lv_enabled = config_reg[`CFG_LVR_EN];
  assign lv_fire = lv_enabled && low_supply && (lv_cnt_reg >= LV_QUALIFY_CYCLES);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !low_supply || !lv_enabled)
      lv_cnt_reg <= 32'h0;
    else if (lv_cnt_reg < LV_QUALIFY_CYCLES)
      lv_cnt_reg <= lv_cnt_reg + 32'h1;
  end

  // Event decode
  logic pin_event;
  logic wdt_run_event;
  logic wdt_sleep_event;
  logic full_reset;
  assign pin_event = pin_low || lv_fire;
  assign wdt_run_event = wdt_event && !in_power_down && (state_reg == ST_RUN);
  assign wdt_sleep_event = wdt_event && in_power_down && (state_reg == ST_RUN);
  // A sleep time-out resets only PC, SP and the watchdog count, everything else is a full reset
  assign full_reset = pin_event || wdt_run_event;

  // Sequencer: hold while the pin or low-voltage source is active, then count the delay.
  // A pin or low-voltage source that returns during the delay sends it back to hold, so the
  // full delay always follows the last release. A sleep time-out skips the
  // hold state: nothing outside is pulling reset, and only the delay applies.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD:
        if (!pin_event)
          state_next = ST_DELAY;
      ST_DELAY:
        if (pin_event)
          state_next = ST_HOLD;
        else if (delay_cnt_reg >= RESET_DELAY_CYCLES)
          state_next = ST_RUN;
      ST_RUN:
        if (full_reset)
          state_next = ST_HOLD;
        else if (wdt_sleep_event)
          state_next = ST_DELAY;
      default:
        state_next = ST_HOLD;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= ST_HOLD;
    else
      state_reg <= state_next;
  end

  // Start-up timer restarts on every entry to the delay state
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_reg != ST_DELAY)
      delay_cnt_reg <= 32'h0;
    else
      delay_cnt_reg <= delay_cnt_reg + 32'h1;
  end

  // Cause record; power-on is the wake state after rst_i
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cause_reg <= CAUSE_POWER_ON;
    else if (state_reg == ST_RUN && wdt_sleep_event && !pin_event)
      cause_reg <= CAUSE_WDT_SLEEP;
    else if (state_reg == ST_RUN && wdt_run_event && !pin_event)
      cause_reg <= CAUSE_WDT_RUN;
    else if (state_reg == ST_RUN && pin_low)
      cause_reg <= CAUSE_PIN;
    else if (state_reg == ST_RUN && lv_fire)
      cause_reg <= CAUSE_LOW_VOLTAGE;
  end

  // Wishbone decode; one-cycle answer, ack dropped the cycle after
  logic wb_req;
  logic wr_en;
  logic addr_ok;
  logic [7:0] wbyte;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign addr_ok = (wb_adr_i <= `ADDR_PTR);
  assign wr_en = wb_req && wb_we_i && addr_ok && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = wr_en && (a == idx);
  endfunction

  // Sticky cold flag marks that the next delay follows power-on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cold_reg <= 1'b1;
    else if (state_reg == ST_RUN)
      cold_reg <= 1'b0;
  end

  // Flags: cleared on power-on, kept on pin/LV, set by watchdog.
  // Hardware events take priority over a bus write in the same cycle, and
  // the bus can only reach bits 3:0, so a time-out record is never lost.
  // Software reads bits 5:4 after wake-up to tell the reset causes apart.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_reg <= 8'h00;
    else if (wdt_sleep_event)
    begin
      flags_reg[`FLAG_TO] <= 1'b1;
      flags_reg[`FLAG_PD] <= 1'b1;
    end
    else if (wdt_run_event)
      flags_reg[`FLAG_TO] <= 1'b1;
    else if (halt_req_i && state_reg == ST_RUN)
      flags_reg[`FLAG_PD] <= 1'b1;
    else if (hit(wb_adr_i, `ADDR_STATUS))
      flags_reg[3:0] <= wbyte[3:0]; // Bus reaches bits 3:0 only; TO and PD are hardware-owned
  end

  // Configuration and watchdog setup
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      config_reg <= `CONFIG_RST;
    else if (hit(wb_adr_i, `ADDR_CONFIG))
      config_reg <= wbyte;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || full_reset)
      wdt_setup_reg <= `WDT_SETUP_RST;
    else if (hit(wb_adr_i, `ADDR_WDT_SETUP))
      wdt_setup_reg <= wbyte;
  end

  // Interrupt control 0 clears on full resets only; bit 7 unimplemented
  always_ff @(posedge clk_i)
  begin
    if (rst_i || full_reset)
      interrupt_control_0_reg <= `INTERRUPT_CONTROL_0_RST;
    else if (hit(wb_adr_i, `ADDR_INTERRUPT_CONTROL_0))
      interrupt_control_0_reg <= wbyte & `INTERRUPT_CONTROL_0_IMPL;
  end

  // Watchdog counter clears on any reset and counts on immediately
  always_ff @(posedge clk_i)
  begin
    if (rst_i || full_reset || wdt_sleep_event || wdt_clear_i)
      wdt_count_reg <= 16'h0000;
    else
      wdt_count_reg <= wdt_count_reg + 16'h0001;
  end

  // Accumulator and pointer survive every reset except power-on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_reg <= 8'h00; // undefined value modelled as zero
      ptr_reg <= 8'h00;
    end
    else
    begin
      if (hit(wb_adr_i, `ADDR_ACC))
        acc_reg <= wbyte;
      if (hit(wb_adr_i, `ADDR_PTR))
        ptr_reg <= wbyte;
    end
  end

  // Outputs towards the core.
  // All of them are registered, so the core never sees decode glitches.
  // The run line follows the next state, which removes one cycle of delay
  // between the sequencer deciding and the core being released or stopped.
  // Port and timer state survive a sleep time-out: the core resumes with
  // its pins as it left them, only the program counter and stack restart.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_low_o <= `PC_RST;
      stack_ptr_o <= `SP_RST;
      port_a_o <= `PORT_RST;
      port_a_dir_o <= `PORT_RST;
      cpu_run_o <= 1'b0;
      timers_on_o <= 1'b0;
      irq_enable_o <= 1'b0;
    end
    else
    begin
      cpu_run_o <= (state_next == ST_RUN);
      irq_enable_o <= interrupt_control_0_reg[0] && !full_reset;
      if (full_reset || wdt_sleep_event)
      begin
        pc_low_o <= `PC_RST;
        stack_ptr_o <= `SP_RST;
      end
      else if (hit(wb_adr_i, `ADDR_PC_LOW))
        pc_low_o <= wbyte;
      if (full_reset)
      begin
        port_a_o <= `PORT_RST;
        port_a_dir_o <= `PORT_RST;
        timers_on_o <= 1'b0;
      end
      else
      begin
        if (hit(wb_adr_i, `ADDR_PORT_A))
          port_a_o <= wbyte;
        if (hit(wb_adr_i, `ADDR_PORT_A_DIR))
          port_a_dir_o <= wbyte;
        if (hit(wb_adr_i, `ADDR_CONFIG))
          timers_on_o <= wbyte[1];
      end
    end
  end

  // Read mux; unused upper bits read zero
  logic [7:0] rd_byte;
  assign rd_byte =
    (wb_adr_i == `ADDR_STATUS) ? flags_reg :
    (wb_adr_i == `ADDR_WDT_SETUP) ? wdt_setup_reg :
    (wb_adr_i == `ADDR_INTERRUPT_CONTROL_0) ? interrupt_control_0_reg :
    (wb_adr_i == `ADDR_PC_LOW) ? pc_low_o :
    (wb_adr_i == `ADDR_PORT_A) ? port_a_o :
    (wb_adr_i == `ADDR_PORT_A_DIR) ? port_a_dir_o :
    (wb_adr_i == `ADDR_ACC) ? acc_reg :
    (wb_adr_i == `ADDR_CAUSE) ? {4'h0, cold_reg, cause_reg} :
    (wb_adr_i == `ADDR_CONFIG) ? config_reg :
    (wb_adr_i == `ADDR_WDT_COUNT) ? wdt_count_reg[15:8] :
    ptr_reg;

  // Bus answer registered one cycle after the request is seen.
  // A request seen while ack or err is still high is not taken again, so a
  // master that drops stb one cycle after the answer gets exactly one pulse.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req && addr_ok;
      wb_err_o <= wb_req && !addr_ok;
      wb_dat_o <= (wb_req && addr_ok && !wb_we_i) ? {24'h0, rd_byte} : 32'h0;
    end
  end

endmodule

`default_nettype wire

// ---- bench/rst_ctrl_chk.sv ----
// Assertions on the reset controller ports.
// Assumes a reset delay of 8 cycles and the pin high at each reset.
`timescale 1ns/1ps
`default_nettype none
module rst_ctrl_chk(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic external_reset_pin_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic power_down_i,
  input wire logic cpu_run_o,
  input wire logic [7:0] pc_low_o,
  input wire logic [2:0] stack_ptr_o,
  input wire logic timers_on_o,
  input wire logic irq_enable_o,
  input wire logic [7:0] port_a_o,
  input wire logic [7:0] port_a_dir_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Five samples leave room for the two-stage synchroniser
  property p_pin_hold; !external_reset_pin_n_i[*5] |-> !cpu_run_o; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("run with pin low");
  property p_pc_zero; !cpu_run_o[*2] |-> pc_low_o == 8'h00; endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("pc not zero");
  property p_irq_off; !cpu_run_o[*2] |-> !irq_enable_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq on in reset");
  property p_ports; $fell(rst_i) |-> port_a_o == 8'hFF && port_a_dir_o == 8'hFF; endproperty
  a_ports: assert property (p_ports) else $error("ports not ones");
  property p_stack; $fell(rst_i) |-> stack_ptr_o == 3'h7; endproperty
  a_stack: assert property (p_stack) else $error("stack not at top");
  property p_timers; $fell(rst_i) |-> !timers_on_o ##1 !timers_on_o; endproperty
  a_timers: assert property (p_timers) else $error("timers on");
  // Start-up timer: eight cycles held, then run within a bounded wait
  property p_delay; $fell(rst_i) |-> !cpu_run_o[*8] ##[1:12] cpu_run_o; endproperty
  a_delay: assert property (p_delay) else $error("start delay wrong");
  property p_wdt;
    (cpu_run_o && !power_down_i && watchdog_timeout_i)[*3] |-> ##[0:4] !cpu_run_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog ignored");
endmodule
bind rst_ctrl rst_ctrl_chk u_chk(.clk_i, .rst_i, .external_reset_pin_n_i,
  .watchdog_timeout_i, .power_down_i, .cpu_run_o, .pc_low_o, .stack_ptr_o,
  .timers_on_o, .irq_enable_o, .port_a_o, .port_a_dir_o);
`default_nettype wire

// ---- bench/reset_network.sv ----
// Pull-up, capacitor and push switch on the reset pin.
// Assumes the switch is pressed and released just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module reset_network #(parameter int RC_CYC = 6)(
  input wire logic clk_i,
  input wire logic press_i,
  output logic pin_n_o
);
  int chg = RC_CYC;
  // Switch empties the cap; the pull-up recharges it, so release is late
  always_ff @(posedge clk_i)
  begin
    if (press_i)
      chg <= 0;
    else if (chg < RC_CYC)
      chg <= chg + 1;
  end
  assign pin_n_o = (chg >= RC_CYC);
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Bench for the reset controller: sources, reset values, register bus.
// Assumes reset_network on the pin and the checker bound to rst_ctrl.
`include "rst_ctrl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1, press = 0, low_supply_i = 0, halt_req_i = 0;
  logic watchdog_timeout_i = 0, power_down_i = 0;
  logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, wb_err_o, cpu_run_o, timers_on_o, irq_enable_o;
  logic external_reset_pin_n_i;
  logic [7:0] pc_low_o, port_a_o, port_a_dir_o;
  logic [2:0] stack_ptr_o;
  int num_errors = 0, tests_run = 0, waited;
  always #50 clk_i = ~clk_i;
  reset_network u_net(.clk_i, .press_i(press), .pin_n_o(external_reset_pin_n_i));
  rst_ctrl #(.RESET_DELAY_CYCLES(8), .LV_QUALIFY_CYCLES(4)) u_dut(.clk_i, .rst_i,
    .external_reset_pin_n_i, .low_supply_i, .watchdog_timeout_i, .power_down_i,
    .halt_req_i, .wdt_clear_i(1'b0), .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF),
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cpu_run_o,
    .pc_low_o, .stack_ptr_o, .timers_on_o, .irq_enable_o, .port_a_o, .port_a_dir_o);
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until ack or err is sampled, released at that edge
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] r, output logic e);
    int i;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h0, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (i = 0; i < 40 && wb_ack_o !== 1'b1 && wb_err_o !== 1'b1; i++)
      @(posedge clk_i);
    r = wb_dat_o[7:0];
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i >= 40)
    begin
      chk("bus wait", 0, 1);
      close_out();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    bus(a, 1'b0, 8'h00, r, e);
    chk($sformatf("reg %h", a), r & m, x);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    bus(a, 1'b1, d, r, e);
  endtask
  // Bounded wait for the run line; the count feeds the delay check
  task automatic wait_run(input logic v);
    for (waited = 0; waited < 60 && cpu_run_o !== v; waited++)
      @(posedge clk_i);
    chk("run", cpu_run_o, v);
    if (waited >= 60)
      close_out();
  endtask
  task automatic t_por;
    logic [7:0] r;
    logic e;
    rd(`ADDR_STATUS, 8'h30, 8'h00);
    rd(`ADDR_WDT_SETUP, 8'hFF, `WDT_SETUP_RST);
    rd(`ADDR_INTERRUPT_CONTROL_0, 8'hFF, `INTERRUPT_CONTROL_0_RST);
    rd(`ADDR_PC_LOW, 8'hFF, `PC_RST);
    rd(`ADDR_PORT_A, 8'hFF, `PORT_RST);
    rd(`ADDR_PORT_A_DIR, 8'hFF, `PORT_RST);
    chk("timers", timers_on_o, 0);
    bus(4'hF, 1'b0, 8'h00, r, e);
    chk("err", e, 1);
  endtask
  task automatic t_pin;
    wait_run(1'b1);
    wr(`ADDR_PORT_A, 8'h12);
    wr(`ADDR_ACC, 8'h5A);
    wr(`ADDR_INTERRUPT_CONTROL_0, 8'h01);
    @(posedge clk_i);
    chk("irq on", irq_enable_o, 1);
    press <= 1'b1;
    wait_run(1'b0);
    repeat (10) @(posedge clk_i);
    chk("held", cpu_run_o, 0);
    chk("pc", pc_low_o, 0);
    press <= 1'b0;
    wait_run(1'b1);
    chk("delay", waited >= 14, 1);
    rd(`ADDR_PORT_A, 8'hFF, 8'hFF);
    rd(`ADDR_ACC, 8'hFF, 8'h5A);
    rd(`ADDR_INTERRUPT_CONTROL_0, 8'hFF, 8'h00);
    rd(`ADDR_STATUS, 8'h30, 8'h00);
  endtask
  task automatic t_lv;
    low_supply_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    low_supply_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("short dip", cpu_run_o, 1);
    low_supply_i <= 1'b1;
    wait_run(1'b0);
    low_supply_i <= 1'b0;
    wait_run(1'b1);
    rd(`ADDR_STATUS, 8'h30, 8'h00);
  endtask
  task automatic t_wdt(input logic sleep);
    wr(`ADDR_WDT_SETUP, 8'h03);
    wr(`ADDR_PORT_A, 8'h3C);
    power_down_i <= sleep;
    halt_req_i <= sleep;
    @(posedge clk_i);
    halt_req_i <= 1'b0;
    watchdog_timeout_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    watchdog_timeout_i <= 1'b0;
    wait_run(1'b0);
    chk("pc", pc_low_o, 0);
    chk("sp", stack_ptr_o, 3'h7);
    power_down_i <= 1'b0;
    wait_run(1'b1);
    rd(`ADDR_STATUS, 8'h30, {2'b00, 1'b1, sleep, 4'h0});
    rd(`ADDR_WDT_SETUP, 8'hFF, sleep ? 8'h03 : 8'h07);
    rd(`ADDR_PORT_A, 8'hFF, sleep ? 8'h3C : 8'hFF);
    rd(`ADDR_PC_LOW, 8'hFF, 8'h00);
    rd(`ADDR_ACC, 8'hFF, 8'h5A);
  endtask
  // Main sequence ends with a mid-run power-on reset over set flags
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_por();
    t_pin();
    t_lv();
    t_wdt(1'b0);
    t_wdt(1'b1);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_por();
    close_out();
  end
endmodule
`default_nettype wire
